// file: rtl/rsq_seq.sv
`timescale 1ns/100ps
`default_nettype none
module rsq_seq
    import rsq_pkg::*;
#(
    parameter int HOLD_XTAL = HOLD_XTAL_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic supply_ok,
    input wire logic brownout_reset,
    input wire logic watchdog_timeout,
    input wire logic watchdog_action_option,
    input wire logic brownout_stop_keepalive_option,
    input wire logic crystal_option,
    input wire logic stop_mode,
    input wire logic debug_pin_line,
    input wire logic reset_pin_func_en,
    input wire logic reset_shared_pin_i,
    output logic reset_shared_pin_o,
    output logic reset_shared_pin_oe,
    input wire logic [7:0] gpio_in,
    output logic cpu_reset,
    output logic periph_reset,
    output logic smr_ctl_reset,
    output logic port_reset,
    output logic ipo_select,
    output logic osc_keep_running,
    output logic vector_fetch,
    output logic [15:0] vector_addr,
    output logic watchdog_irq,
    output logic brownout_enable,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_START_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_BASE_LAST = CNT_W'(HOLD_BASE_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_XTAL_LAST = CNT_W'(HOLD_XTAL - 1);
    localparam logic [1:0] PIN_ACCEPT = 2'(PIN_MIN_CYCLES - 1);

    rsq_regs_t q;
    rsq_regs_t d;
    logic power_bad;
    logic pin_req;
    logic wdt_reset_req;
    logic dbg_low_req;
    logic sys_req;
    logic smr_req;
    logic [7:0] gpio_change;
    logic in_reset;
    logic [CNT_W-1:0] hold_last;
    logic do_write;
    logic rd_take;
    logic [3:0] rd_ofs;

    // Request decode
    always_comb
    begin
        power_bad = !supply_ok || (brownout_reset && q.bo_enable);
        pin_req = reset_pin_func_en && !q.sync2 && (q.pin_cnt == PIN_ACCEPT);
        wdt_reset_req = watchdog_timeout && watchdog_action_option && !stop_mode;
        dbg_low_req = stop_mode && !debug_pin_line;
        sys_req = power_bad || wdt_reset_req || pin_req || q.dbg_rst || dbg_low_req;
        gpio_change = (gpio_in ^ q.gpio_prev) & q.smr_en;
        smr_req = stop_mode && (watchdog_timeout || (|gpio_change));
        in_reset = (q.st != ST_RUN);
        hold_last = q.xtal_opt ? HOLD_XTAL_LAST : HOLD_BASE_LAST;
        do_write = q.aw_hold && q.w_hold && !q.bvalid;
        rd_take = s_axi_arvalid && q.arready;
        rd_ofs = s_axi_araddr[3:0];
    end

    // Next state of the whole block
    always_comb
    begin
        d = q;
        d.vector_fetch = 1'b0;
        d.wdt_irq = 1'b0;
        d.osc_run = 1'b1;
        d.vector_addr = RESET_VECTOR_ADDR;
        // Two-stage synchronizer, then low-width counter
        d.sync1 = reset_shared_pin_i;
        d.sync2 = q.sync1;
        if (q.sync2 || !reset_pin_func_en)
        begin
            d.pin_cnt = 2'h0;
        end
        else if (q.pin_cnt != PIN_ACCEPT)
        begin
            d.pin_cnt = q.pin_cnt + 2'h1;
        end
        d.gpio_prev = gpio_in;
        // Reset read clear, set by new events wins below
        if (rd_take && rd_ofs == OFS_CAUSE)
        begin
            d.cause = q.cause & ~CAUSE_RD_CLR;
        end
        // Sequencer
        unique case (q.st)
            ST_RUN:
            begin
                if (watchdog_timeout && !watchdog_action_option && !stop_mode)
                begin
                    d.wdt_irq = 1'b1;
                end
                if (sys_req)
                begin
                    d.st = power_bad ? ST_POWER : ST_OSC;
                    d.cnt = '0;
                    d.smr_kind = 1'b0;
                    d.cause = 8'h00;
                    d.cause[CAUSE_POR] = power_bad || q.dbg_rst;
                    d.cause[CAUSE_WDT] = wdt_reset_req;
                    d.cause[CAUSE_EXT] = pin_req && !power_bad;
                end
                else if (smr_req)
                begin
                    d.st = ST_OSC;
                    d.cnt = '0;
                    d.smr_kind = 1'b1;
                    d.cause[CAUSE_STOP] = 1'b1;
                    d.cause[CAUSE_WDT] = watchdog_timeout;
                end
            end
            ST_POWER:
            begin
                d.cnt = '0;
                d.smr_kind = 1'b0;
                d.cause[CAUSE_POR] = 1'b1;
                if (!power_bad)
                begin
                    d.st = ST_OSC;
                end
            end
            ST_OSC:
            begin
                d.cnt = q.cnt + CNT_W'(1);
                if (power_bad)
                begin
                    d.st = ST_POWER;
                end
                else if (q.cnt == OSC_LAST)
                begin
                    d.st = ST_HOLD;
                    d.cnt = '0;
                end
            end
            ST_HOLD:
            begin
                d.cnt = q.cnt + CNT_W'(1);
                if (power_bad)
                begin
                    d.st = ST_POWER;
                end
                else if (q.cnt == hold_last)
                begin
                    d.cnt = '0;
                    // Own drive keeps the line low here, so release it and then watch the line
                    if (reset_pin_func_en && (q.pin_oe || !q.sync2))
                    begin
                        d.st = ST_PIN;
                    end
                    else
                    begin
                        d.st = ST_RUN;
                        d.vector_fetch = 1'b1;
                    end
                end
            end
            ST_PIN:
            begin
                if (power_bad)
                begin
                    d.st = ST_POWER;
                end
                else if (q.sync2 || !reset_pin_func_en)
                begin
                    d.st = ST_RUN;
                    d.vector_fetch = 1'b1;
                end
            end
            default:
            begin
                d.st = ST_POWER;
            end
        endcase
        // Option bits sampled while the oscillator starts
        if (q.st == ST_OSC)
        begin
            d.xtal_opt = crystal_option;
            d.keepalive_opt = brownout_stop_keepalive_option;
        end
        d.bo_enable = !stop_mode || q.keepalive_opt;
        // Reset outputs
        d.cpu_reset = (d.st != ST_RUN);
        d.periph_reset = (d.st != ST_RUN) && !d.smr_kind;
        d.smr_ctl_reset = (d.st != ST_RUN);
        d.port_reset = (d.st != ST_RUN) && !d.smr_kind;
        d.pin_oe = (d.st != ST_RUN) && (d.st != ST_PIN) && !d.smr_kind;
        d.ipo_select = (d.st != ST_RUN);
        // Debugger bit clears itself during the reset it starts
        if (in_reset && !q.smr_kind)
        begin
            d.dbg_rst = 1'b0;
        end
        // Write channels
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_hold = 1'b1;
            d.aw_addr = s_axi_awaddr[3:0];
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_hold = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (do_write)
        begin
            d.aw_hold = 1'b0;
            d.w_hold = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            unique case (q.aw_addr)
                OFS_CAUSE:
                begin
                end
                OFS_DBGCTL:
                begin
                    if (q.w_strb[0] && q.w_data[DBG_RST_BIT])
                    begin
                        d.dbg_rst = 1'b1;
                    end
                end
                OFS_SMR_EN:
                begin
                    if (q.w_strb[0])
                    begin
                        d.smr_en = q.w_data[7:0];
                    end
                end
                OFS_STATUS:
                begin
                end
                default:
                begin
                    d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        d.awready = !d.aw_hold && !d.bvalid;
        d.wready = !d.w_hold && !d.bvalid;
        // Read channel
        if (rd_take)
        begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = 32'h0000_0000;
            unique case (rd_ofs)
                OFS_CAUSE:
                begin
                    d.rdata[7:0] = q.cause;
                end
                OFS_DBGCTL:
                begin
                    d.rdata[DBG_RST_BIT] = q.dbg_rst;
                end
                OFS_SMR_EN:
                begin
                    d.rdata[7:0] = q.smr_en;
                end
                OFS_STATUS:
                begin
                    d.rdata[7:0] = {q.st, q.smr_kind, q.xtal_opt, q.keepalive_opt, q.sync2, stop_mode};
                end
                default:
                begin
                    d.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        d.arready = !d.rvalid;
    end

    // State register, reset acts as power-up
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.st <= ST_POWER;
            q.sync1 <= 1'b1;
            q.sync2 <= 1'b1;
            q.cause <= 8'h80;
            q.cpu_reset <= 1'b1;
            q.periph_reset <= 1'b1;
            q.smr_ctl_reset <= 1'b1;
            q.port_reset <= 1'b1;
            q.pin_oe <= 1'b1;
            q.ipo_select <= 1'b1;
            q.osc_run <= 1'b1;
            q.bo_enable <= 1'b1;
            q.vector_addr <= RESET_VECTOR_ADDR;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state register, except the pin output level, which is a constant 0
    assign reset_shared_pin_o = 1'b0;
    assign reset_shared_pin_oe = q.pin_oe;
    assign cpu_reset = q.cpu_reset;
    assign periph_reset = q.periph_reset;
    assign smr_ctl_reset = q.smr_ctl_reset;
    assign port_reset = q.port_reset;
    assign ipo_select = q.ipo_select;
    assign osc_keep_running = q.osc_run;
    assign vector_fetch = q.vector_fetch;
    assign vector_addr = q.vector_addr;
    assign watchdog_irq = q.wdt_irq;
    assign brownout_enable = q.bo_enable;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_osc_then_hold: assert property ((q.st == ST_OSC && q.cnt == OSC_LAST && !power_bad) |=> q.st == ST_HOLD)
        else $error("oscillator start did not lead to hold");
    a_short_hold_len: assert property ((q.st == ST_HOLD && q.cnt == '0 && !q.xtal_opt)
        |-> ##65 (q.st == ST_HOLD || q.st == ST_POWER))
        else $error("hold ended early");
    a_hold_exit: assert property ((q.st == ST_HOLD && q.cnt == hold_last && !power_bad && q.sync2
        && !q.pin_oe) |=> (q.st == ST_RUN && vector_fetch))
        else $error("hold end did not release");
    a_pin_keeps: assert property ((q.st == ST_PIN && !q.sync2 && reset_pin_func_en && !power_bad) |=> cpu_reset)
        else $error("released while pin low");
    a_short_pulse: assert property ((q.st == ST_RUN && !stop_mode && !power_bad && !q.dbg_rst
        && !watchdog_timeout && q.pin_cnt != PIN_ACCEPT && q.smr_en == 8'h00) |=> q.st == ST_RUN)
        else $error("reset without cause");
    a_por_hold: assert property ((q.st == ST_POWER && !supply_ok) |=> q.st == ST_POWER)
        else $error("left power wait while supply low");
    a_por_flag: assert property ((q.st == ST_POWER) |=> q.cause[CAUSE_POR])
        else $error("power cause flag missing");
    a_stop_flag: assert property ((q.st == ST_RUN && !sys_req && smr_req)
        |=> (q.cause[CAUSE_STOP] && q.smr_kind && !periph_reset))
        else $error("stop recovery flags wrong");
    a_wdt_flag: assert property ((q.st == ST_RUN && wdt_reset_req) |=> q.cause[CAUSE_WDT] ##1 cpu_reset)
        else $error("watchdog cause not recorded");
    a_wdt_irq: assert property ((q.st == ST_RUN && watchdog_timeout && !watchdog_action_option && !stop_mode)
        |=> watchdog_irq)
        else $error("watchdog interrupt missing");
    a_pin_drive: assert property ((cpu_reset && !q.smr_kind && q.st != ST_PIN) |-> reset_shared_pin_oe)
        else $error("reset pin not driven");
    a_sync_path: assert property (q.sync2 == $past(q.sync1))
        else $error("synchronizer stage skipped");
    c_sys_reset: cover property (q.st == ST_RUN ##1 q.st == ST_OSC ##[1:300] q.st == ST_RUN);
    c_stop_rec: cover property (q.st == ST_RUN && smr_req && !sys_req);
    c_pin_wait: cover property (q.st == ST_PIN);
endmodule
`default_nettype wire

// file: rtl/rsq_pkg.sv
// Operation
// - Normal or halt: power-on, brownout, watchdog reset, pin or debugger bit start reset.
// - In stop mode, watchdog time-out or enabled port pin change starts stop recovery.
// - Without crystal, processor reset is held 66 oscillator cycles.
// - With crystal option, the hold lengthens to 5000 oscillator cycles.
// - A 4 us oscillator start-up interval precedes the hold count.
// - Stop recovery resets processor, watchdog and clock control registers only.
// - Power or brownout resets count only after supply exceeds power-on threshold.
// - Reset pin still low after the hold keeps the device in reset.
// - Reset start makes all port pins inputs without pull-ups, except the shared pin.
// - Shared pin becomes open-drain reset line driven low during port reset, except in ST_PIN after the hold.
// - Processor and peripherals idle in reset; crystal and watchdog oscillators run.
// - Reset loads control registers with reset values; pointers, flags, RAM undefined.
// - Leaving reset, processor fetches its start vector from bytes 0002h and 0003h.
// - After system reset the internal oscillator is the selected system clock.
// - Normal or halt: reset pin pulses under three clocks are ignored.
// - Debugger-requested reset resets everything except the debugger.
// - Power-on or brownout recovery sets the power-on cause flag.
// - Supply below power-on threshold holds reset, then full power-on sequence follows.
// - Brownout detection during stop is chosen by an option bit read at configuration.
// - Watchdog time-out resets when action option is 1, interrupts when 0.
// - Watchdog-caused reset sets the watchdog cause flag.
// - Any stop recovery sets the stop recovery flag.
package rsq_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int OSC_START_NS = 4000;
    localparam int OSC_START_CYCLES = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_BASE_CYCLES = 66;
    localparam int HOLD_XTAL_CYCLES = 5000;
    localparam int PIN_MIN_CYCLES = 3;
    localparam int CNT_W = 13;
    // Register byte offsets
    localparam logic [3:0] OFS_CAUSE = 4'h0;
    localparam logic [3:0] OFS_DBGCTL = 4'h4;
    localparam logic [3:0] OFS_SMR_EN = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    // Reset cause field positions
    localparam int CAUSE_POR = 7;
    localparam int CAUSE_STOP = 6;
    localparam int CAUSE_WDT = 5;
    localparam int CAUSE_EXT = 4;
    localparam logic [7:0] CAUSE_RD_CLR = 8'hf0;
    localparam int DBG_RST_BIT = 0;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_POWER = 3'b001,
        ST_OSC = 3'b010,
        ST_HOLD = 3'b011,
        ST_PIN = 3'b100
    } rsq_state_t;

    typedef struct packed {
        rsq_state_t st;
        logic [CNT_W-1:0] cnt;
        logic smr_kind;
        logic sync1;
        logic sync2;
        logic [1:0] pin_cnt;
        logic [7:0] gpio_prev;
        logic [7:0] cause;
        logic dbg_rst;
        logic [7:0] smr_en;
        logic xtal_opt;
        logic keepalive_opt;
        logic cpu_reset;
        logic periph_reset;
        logic smr_ctl_reset;
        logic port_reset;
        logic pin_oe;
        logic ipo_select;
        logic osc_run;
        logic vector_fetch;
        logic [15:0] vector_addr;
        logic wdt_irq;
        logic bo_enable;
        logic aw_hold;
        logic [3:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rsq_regs_t;
endpackage

// file: sim/rsq_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module rsq_far_model
(
    input wire logic aclk,
    input wire logic pin_oe,
    input wire logic pin_o,
    input wire logic ext_low,
    output logic pin_level,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr,
    output logic [15:0] start_pc,
    output int fetch_cnt
);
    // Reset line has a pull-up, so it is low only while someone pulls it
    assign pin_level = !((pin_oe && !pin_o) || ext_low);

    // Processor side: takes the start vector address on each fetch pulse
    logic [15:0] pc_q = 16'hffff;
    int fetch_q = 0;
    assign start_pc = pc_q;
    assign fetch_cnt = fetch_q;
    always @(posedge aclk)
    begin
        if (vector_fetch === 1'b1)
        begin
            pc_q <= vector_addr;
            fetch_q <= fetch_q + 1;
        end
    end
endmodule
`default_nettype wire

// file: sim/test_rsq_seq.sv
`timescale 1ns/100ps
`default_nettype none
module test_rsq_seq;
    import rsq_pkg::*;
    localparam int HX = 100;
    localparam int T_SYS = OSC_START_CYCLES + HOLD_BASE_CYCLES;
    // A released reset line passes both synchronizer stages before the run starts
    localparam int T_REL = T_SYS + 3;
    logic aclk = 0, aresetn = 0, supply_ok = 0, brownout_reset = 0, watchdog_timeout = 0;
    logic watchdog_action_option = 1, brownout_stop_keepalive_option = 0, crystal_option = 0;
    logic stop_mode = 0, debug_pin_line = 1, reset_pin_func_en = 1, ext_low = 0, pin_level;
    logic [7:0] gpio_in = 8'h00;
    logic pin_o, pin_oe, cpu_reset, periph_reset, smr_ctl_reset, port_reset, ipo_select;
    logic osc_keep_running, vector_fetch, watchdog_irq, brownout_enable;
    logic [15:0] vector_addr, start_pc;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int fetch_cnt, fails = 0, checks = 0;

    always #25 aclk = ~aclk;

    rsq_seq #(.HOLD_XTAL(HX)) i_rsq_seq (.aclk(aclk), .aresetn(aresetn), .supply_ok(supply_ok),
        .brownout_reset(brownout_reset), .watchdog_timeout(watchdog_timeout),
        .watchdog_action_option(watchdog_action_option),
        .brownout_stop_keepalive_option(brownout_stop_keepalive_option),
        .crystal_option(crystal_option), .stop_mode(stop_mode), .debug_pin_line(debug_pin_line),
        .reset_pin_func_en(reset_pin_func_en), .reset_shared_pin_i(pin_level),
        .reset_shared_pin_o(pin_o), .reset_shared_pin_oe(pin_oe), .gpio_in(gpio_in),
        .cpu_reset(cpu_reset), .periph_reset(periph_reset), .smr_ctl_reset(smr_ctl_reset),
        .port_reset(port_reset), .ipo_select(ipo_select), .osc_keep_running(osc_keep_running),
        .vector_fetch(vector_fetch), .vector_addr(vector_addr), .watchdog_irq(watchdog_irq),
        .brownout_enable(brownout_enable), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    rsq_far_model i_rsq_far_model (.aclk(aclk), .pin_oe(pin_oe), .pin_o(pin_o), .ext_low(ext_low),
        .pin_level(pin_level), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
        .start_pc(start_pc), .fetch_cnt(fetch_cnt));

    // Value and count comparisons
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        checks++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("FAIL %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (!ad && awready === 1'b1)
            begin
                ad = 1;
                awvalid <= 0;
            end
            if (!wd && wready === 1'b1)
            begin
                wd = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    // Length of the processor reset, counted from now or from its rise
    task automatic rst_len(output int n);
        while (cpu_reset !== 1'b1) @(posedge aclk);
        n = 0;
        while (cpu_reset === 1'b1)
        begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic pulse_wdt;
        watchdog_timeout <= 1;
        @(posedge aclk);
        watchdog_timeout <= 0;
    endtask

    // Power-on: waits for supply, then start-up plus hold, then vector fetch
    task automatic t_por;
        int n;
        logic [31:0] d;
        logic [1:0] r;
        cyc(10);
        chk({cpu_reset, periph_reset, smr_ctl_reset, port_reset, pin_oe, pin_o, ipo_select, osc_keep_running},
            8'hfb, "outputs in reset");
        supply_ok <= 1;
        rst_len(n);
        chk_rng(n, T_REL, T_REL + 2, "por length");
        cyc(2);
        chk(fetch_cnt, 1, "fetch count");
        chk(start_pc, RESET_VECTOR_ADDR, "start vector");
        chk({port_reset, pin_oe}, 2'b00, "ports released");
        rd(32'(OFS_CAUSE), d, r);
        chk(d, 32'h80, "por cause");
        rd(32'(OFS_CAUSE), d, r);
        chk(d, 32'h00, "cause read clear");
    endtask

    // Reset pin: short pulse ignored, long hold extends reset
    task automatic t_pin;
        logic [31:0] d;
        logic [1:0] r;
        ext_low <= 1;
        cyc(2);
        ext_low <= 0;
        cyc(12);
        chk(cpu_reset, 0, "short pulse");
        ext_low <= 1;
        cyc(T_SYS + 40);
        chk(cpu_reset, 1, "pin held");
        ext_low <= 0;
        cyc(8);
        chk(cpu_reset, 0, "pin release");
        rd(32'(OFS_CAUSE), d, r);
        chk(d[7:4], 4'b0001, "ext cause");
    endtask

    // Watchdog: interrupt when option is 0, reset when 1
    task automatic t_wdt;
        int n;
        logic seen;
        logic [31:0] d;
        logic [1:0] r;
        seen = 0;
        watchdog_action_option <= 0;
        cyc(1);
        pulse_wdt();
        repeat (4)
        begin
            @(posedge aclk);
            seen = seen | (watchdog_irq === 1'b1);
        end
        chk({seen, cpu_reset}, 2'b10, "wdt interrupt");
        watchdog_action_option <= 1;
        cyc(1);
        pulse_wdt();
        rst_len(n);
        chk_rng(n, T_SYS - 2, T_SYS + 4, "wdt length");
        rd(32'(OFS_CAUSE), d, r);
        chk({d[7], d[5]}, 2'b01, "wdt cause");
    endtask

    // Debugger bit with crystal option: long hold, bit clears itself
    task automatic t_dbg;
        int n;
        logic [31:0] d;
        logic [1:0] r;
        crystal_option <= 1;
        wr(32'(OFS_DBGCTL), 32'h1, r);
        chk(r, RESP_OKAY, "dbg write");
        rst_len(n);
        chk_rng(n, OSC_START_CYCLES + HX - 3, OSC_START_CYCLES + HX + 4, "xtal length");
        crystal_option <= 0;
        rd(32'(OFS_DBGCTL), d, r);
        chk(d[0], 0, "dbg bit clear");
        rd(32'(OFS_CAUSE), d, r);
        chk(d[7], 1, "dbg cause");
    endtask

    // One stop-mode wake: processor leaves stop once reset starts
    task automatic stop_rec(input logic ep, input logic [3:0] ec, input logic [3:0] m);
        int n;
        logic [1:0] pr;
        logic [31:0] d;
        logic [1:0] r;
        while (cpu_reset !== 1'b1) @(posedge aclk);
        stop_mode <= 0;
        debug_pin_line <= 1;
        pr = {periph_reset, smr_ctl_reset};
        rst_len(n);
        chk(pr, {ep, 1'b1}, "recovery kind");
        chk_rng(n, T_SYS - 2, T_SYS + 4, "recovery length");
        rd(32'(OFS_CAUSE), d, r);
        chk(d[7:4] & m, ec, "recovery cause");
    endtask

    task automatic t_stop;
        logic [31:0] d;
        logic [1:0] r;
        wr(32'(OFS_SMR_EN), 32'h01, r);
        rd(32'(OFS_SMR_EN), d, r);
        chk(d, 32'h01, "enable readback");
        chk(r, RESP_OKAY, "read okay");
        stop_mode <= 1;
        cyc(3);
        chk(brownout_enable, 0, "brownout off in stop");
        gpio_in[1] <= 1;
        cyc(8);
        chk(cpu_reset, 0, "disabled pin");
        gpio_in[0] <= 1;
        stop_rec(0, 4'b0100, 4'b1111);
        stop_mode <= 1;
        cyc(3);
        pulse_wdt();
        stop_rec(0, 4'b0110, 4'b1111);
        stop_mode <= 1;
        cyc(3);
        debug_pin_line <= 0;
        stop_rec(1, 4'b0000, 4'b0000);
        chk(fetch_cnt, 7, "fetch count");
    endtask

    // Brownout: held while supply is low, then full power-on sequence
    task automatic t_bo;
        int n;
        logic [31:0] d;
        logic [1:0] r;
        brownout_reset <= 1;
        supply_ok <= 0;
        cyc(20);
        chk(cpu_reset, 1, "brownout hold");
        brownout_reset <= 0;
        supply_ok <= 1;
        rst_len(n);
        chk_rng(n, T_REL, T_REL + 2, "brownout length");
        rd(32'(OFS_CAUSE), d, r);
        chk(d[7:4], 4'b1000, "brownout cause");
        rd(32'h3, d, r);
        chk(r, RESP_SLVERR, "unmapped read");
        wr(32'h9, 32'h1, r);
        chk(r, RESP_SLVERR, "unmapped write");
    endtask

    task automatic test_done;
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #(20000 * 50);
        fails++;
        test_done();
    end

    initial
    begin
        cyc(16);
        aresetn <= 1;
        cyc(2);
        t_por();
        t_pin();
        t_wdt();
        t_dbg();
        t_stop();
        t_bo();
        test_done();
    end
endmodule
`default_nettype wire
